// ---- hdl/sar_adc_control.v ----
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.vh"

// Function
// - Irq off: done flag set per conversion, cleared by control write or result read.
// - Irq on: done flag bit is software read/write, selects CPU servicing.
// - Reset clears done flag and interrupt enable.
// - With interrupt enable set, request raised at every conversion end.
// - Result read or control write drops pending interrupt request.
// - Continuous bit repeats conversions; clear runs one; reset clears it.
// - Channel codes 0 to 14 select external inputs in order.
// - Codes 11101 and 11110 route high and low internal references.
// - All ones powers converter off; reset sets all ones.
// - Unused codes 0F-1A, 11100 give undefined results; 11011 reserved.
// - One 8-bit result register rewritten on every conversion.
// - Prescaler divides input clock by 1, 2, 4, 8 or 16.
// - Source bit picks bus clock at one, oscillator at zero; reset oscillator.
// - Control write starts conversion finishing in 16 to 17 converter clocks.
// - Continuous mode overwrites result whether read or not.
// - Stop mode aborts conversion; after stop exit it idles until the next control write.
module sar_adc_control (
	input wire clk,
	input wire rst_n,
	input wire clk_en,
	input wire osc_clk_tick,
	input wire stop_mode,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire comparator_high,
	output reg [4:0] channel_select,
	output reg converter_powered,
	output reg sample_hold,
	output reg [7:0] dac_code,
	output reg conv_irq
);

	localparam ST_OFF = 3'b001;
	localparam ST_IDLE = 3'b010;
	localparam ST_CONV = 3'b100;

	reg done_r;
	reg irq_en_r;
	reg cont_r;
	reg [4:0] chan_r;
	reg [2:0] div_r;
	reg src_r;
	reg stop_r;
	reg [7:0] result_r;
	reg [2:0] state_r;
	reg [4:0] cyc_r;
	reg [3:0] pre_r;
	reg [7:0] sar_r;
	reg [7:0] trial_r;
	reg aw_got_r;
	reg w_got_r;
	reg [3:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	////////////////////////////////////////////////////////////////
	// Bus slave

	wire aw_take = s_axi_awvalid && !aw_got_r && !s_axi_bvalid;
	wire w_take = s_axi_wvalid && !w_got_r && !s_axi_bvalid;
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = !w_got_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire have_aw = aw_got_r || aw_take;
	wire have_w = w_got_r || w_take;
	wire wr_fire = have_aw && have_w && !s_axi_bvalid;
	wire [3:0] wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_got_r ? w_data_r : s_axi_wdata;
	wire [3:0] wr_strb = w_got_r ? w_strb_r : s_axi_wstrb;
	wire wr_lane0 = wr_fire && wr_strb[0];
	wire ar_fire = s_axi_arvalid && !s_axi_rvalid;

	wire wr_ctl = wr_lane0 && (wr_addr == `OFF_STATUS_CONTROL);
	wire wr_clk = wr_lane0 && (wr_addr == `OFF_CLOCK_SELECT);
	wire wr_run = wr_lane0 && (wr_addr == `OFF_RUN_CONTROL);
	wire rd_result = ar_fire && (s_axi_araddr == `OFF_RESULT);
	wire wr_known = (wr_addr == `OFF_STATUS_CONTROL) ||
		(wr_addr == `OFF_CLOCK_SELECT) || (wr_addr == `OFF_RUN_CONTROL) ||
		(wr_addr == `OFF_RESULT);

	reg [31:0] rd_mux;
	reg rd_ok;
	always @* begin
		rd_mux = 32'h0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`OFF_STATUS_CONTROL: rd_mux[7:0] = {done_r, irq_en_r, cont_r, chan_r};
			`OFF_RESULT: rd_mux[7:0] = result_r;
			`OFF_CLOCK_SELECT: rd_mux[7:0] = {div_r, src_r, 4'h0};
			`OFF_RUN_CONTROL: rd_mux[0] = stop_r;
			default: rd_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Bus handshake registers

	always @(posedge clk) begin
		if (!rst_n) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h0;
		end else if (clk_en) begin
			// Address and data may arrive in either order
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_got_r <= 1'b1;
					aw_addr_r <= s_axi_awaddr;
				end
				if (w_take) begin
					w_got_r <= 1'b1;
					w_data_r <= s_axi_wdata;
					w_strb_r <= s_axi_wstrb;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end

			// Read data is captured at the address handshake, so a
			// conversion ending while rvalid waits cannot tear it
			if (ar_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Converter clock: prescaled enable from bus or oscillator tick

	wire src_tick = src_r ? 1'b1 : osc_clk_tick;
	reg [3:0] div_mask;
	always @* begin
		case (div_r)
			3'h0: div_mask = 4'h0;
			3'h1: div_mask = 4'h1;
			3'h2: div_mask = 4'h3;
			3'h3: div_mask = 4'h7;
			default: div_mask = 4'hF;
		endcase
	end
	wire conv_tick = src_tick && ((pre_r & div_mask) == div_mask);

	////////////////////////////////////////////////////////////////
	// Conversion sequencer

	wire pwr_off = (chan_r == `CH_POWER_OFF);
	wire conv_end = (state_r == ST_CONV) && conv_tick &&
		(cyc_r == `CONV_CYCLES);
	wire [7:0] sar_next = comparator_high ? sar_r : (sar_r & ~trial_r);

	always @(posedge clk) begin
		if (!rst_n) begin
			done_r <= 1'b0;
			irq_en_r <= 1'b0;
			cont_r <= 1'b0;
			chan_r <= `RST_CHANNEL;
			div_r <= `RST_DIV;
			src_r <= `RST_SRC;
			stop_r <= 1'b0;
			result_r <= 8'h00;
			pre_r <= 4'h0;
			conv_irq <= 1'b0;
		end else if (clk_en) begin
			if (wr_clk) begin
				div_r <= wr_data[`FLD_DIV_HI:`FLD_DIV_LO];
				src_r <= wr_data[`FLD_SRC];
			end
			if (wr_run)
				stop_r <= wr_data[`FLD_STOP];

			if (src_tick)
				pre_r <= pre_r + 4'h1;

			// Flag and request: a conversion end in the same cycle as a
			// clearing access wins, so no completion is lost.
			if (wr_ctl) begin
				irq_en_r <= wr_data[`FLD_IRQ_EN];
				cont_r <= wr_data[`FLD_CONT];
				chan_r <= wr_data[`FLD_CH_HI:`FLD_CH_LO];
			end
			if (conv_end) begin
				result_r <= sar_next;
				// flag and request with the load
				if (!irq_en_r)
					done_r <= 1'b1;
				conv_irq <= irq_en_r;
			end else begin
				if (wr_ctl || rd_result)
					conv_irq <= 1'b0;
				// software owns the bit with interrupts on
				if (wr_ctl)
					done_r <= wr_data[`FLD_IRQ_EN] ? wr_data[`FLD_DONE] : 1'b0;
				else if (rd_result && !irq_en_r)
					done_r <= 1'b0;
			end

		end
	end

	////////////////////////////////////////////////////////////////
	// Conversion steps: state, step counter and trial code

	always @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_OFF;
			cyc_r <= 5'h00;
			sar_r <= 8'h00;
			trial_r <= 8'h00;
		end else if (clk_en) begin
			// stop mode or stop bit aborts; a power-off write also forces the off state
			if (stop_mode || stop_r || (wr_ctl &&
				wr_data[`FLD_CH_HI:`FLD_CH_LO] == `CH_POWER_OFF)) begin
				state_r <= ST_OFF;
			end else begin
				case (state_r)
					ST_OFF: begin
						if (wr_ctl) begin
							state_r <= ST_CONV;
							cyc_r <= 5'h00;
						end else if (!pwr_off) begin
							state_r <= ST_IDLE;
						end
					end
					ST_IDLE: begin
						if (wr_ctl) begin
							state_r <= ST_CONV;
							cyc_r <= 5'h00;
						end
					end
					ST_CONV: begin
						if (wr_ctl) begin
							cyc_r <= 5'h00;
						end else if (conv_tick) begin
							if (cyc_r == `CONV_CYCLES) begin
								cyc_r <= 5'h00;
								if (!cont_r)
									state_r <= ST_IDLE;
							end else begin
								cyc_r <= cyc_r + 5'h01;
							end
							if (cyc_r[3:0] == 4'h0) begin
								sar_r <= 8'h80;
								trial_r <= 8'h80;
							end else if (cyc_r[0] == 1'b0 && trial_r != 8'h00) begin
								sar_r <= sar_next | (trial_r >> 1);
								trial_r <= trial_r >> 1;
							end
						end
					end
					default: state_r <= ST_OFF;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Analog side

	always @(posedge clk) begin
		if (!rst_n) begin
			channel_select <= `RST_CHANNEL;
			converter_powered <= 1'b0;
			sample_hold <= 1'b0;
			dac_code <= 8'h00;
		end else if (clk_en) begin
			// code passed to the analog mux as is
			channel_select <= chan_r;
			converter_powered <= !pwr_off && !stop_mode && !stop_r;
			// no sampling once stop is asked for; the sequencer
			// leaves the conversion state only one edge later
			sample_hold <= (state_r == ST_CONV) && (cyc_r == 5'h00) &&
				!stop_mode && !stop_r;
			dac_code <= sar_r;
		end
	end

endmodule // sar_adc_control
`default_nettype wire

// ---- hdl/adc_ctl_consts.vh ----
`ifndef ADC_CTL_CONSTS_VH
`define ADC_CTL_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define OFF_STATUS_CONTROL 4'h0
`define OFF_RESULT 4'h4
`define OFF_CLOCK_SELECT 4'h8
`define OFF_RUN_CONTROL 4'hC

// Status/control register fields
`define FLD_DONE 7
`define FLD_IRQ_EN 6
`define FLD_CONT 5
`define FLD_CH_HI 4
`define FLD_CH_LO 0

// Clock select register fields
`define FLD_DIV_HI 7
`define FLD_DIV_LO 5
`define FLD_SRC 4

// Run control register: stop mode request bit
`define FLD_STOP 0

// Reset values
`define RST_CHANNEL 5'h1F
`define RST_DIV 3'h0
`define RST_SRC 1'b0

// Channel codes
`define CH_LAST_EXT 5'h0E
`define CH_RESERVED 5'h1B
`define CH_HIGH_REF 5'h1D
`define CH_LOW_REF 5'h1E
`define CH_POWER_OFF 5'h1F

// Converter clock cycles per conversion (16, last one closes)
`define CONV_CYCLES 5'h10
`define SAR_BITS 4'h8

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- tb/sar_adc_control_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_monitor (
	input wire clk,
	input wire rst_n,
	input wire clk_en,
	input wire stop_mode,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [4:0] channel_select,
	input wire converter_powered,
	input wire sample_hold,
	input wire [7:0] dac_code,
	input wire conv_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid) else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	a_bvalid_cause: assert property ($rose(s_axi_bvalid) |->
		$past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready))
		else $error("write response without request");
	a_power_off: assert property (
		$past(channel_select) == 5'h1F && channel_select == 5'h1F |->
		!converter_powered) else $error("powered with off code");
	a_stop_off: assert property (
		stop_mode && clk_en |=> !converter_powered && !sample_hold)
		else $error("active in stop mode");
	a_freeze_state: assert property (!clk_en |=>
		$stable(dac_code) && $stable(channel_select))
		else $error("state moved while frozen");
	a_irq_drop: assert property (
		conv_irq && s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h4
		|-> ##[1:3] !conv_irq) else $error("request kept after read");
endmodule // sar_adc_control_monitor
bind sar_adc_control sar_adc_control_monitor sar_adc_control_monitor_inst (
	.clk, .rst_n, .clk_en, .stop_mode, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .channel_select, .converter_powered, .sample_hold,
	.dac_code, .conv_irq);
`default_nettype wire

// ---- tb/adc_analog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
	input wire logic clk,
	input wire logic [4:0] channel_select,
	input wire logic converter_powered,
	input wire logic [7:0] dac_code,
	input wire logic [7:0] vin_base,
	output logic comparator_high
);
	logic [7:0] vin;
	logic noise_r = 1'b0;
	// Unpowered comparator gives no stable answer
	always @(posedge clk) noise_r <= ~noise_r;
	always_comb begin
		if (channel_select == 5'h1D)
			vin = 8'hFF;
		else if (channel_select == 5'h1E)
			vin = 8'h00;
		else
			vin = vin_base + {channel_select, 3'h0};
		comparator_high = converter_powered ? (vin >= dac_code) : noise_r;
	end
endmodule // adc_analog_model
`default_nettype wire

// ---- tb/sar_adc_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_tb_top;
	logic clk = 0, rst_n = 0, clk_en = 1, osc_clk_tick = 0, stop_mode = 0;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [7:0] vin_base = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, comparator_high, converter_powered, sample_hold, conv_irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [4:0] channel_select;
	wire [7:0] dac_code;
	int errors = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) osc_clk_tick <= 1'($urandom);
	sar_adc_control sar_adc_control_inst (.clk, .rst_n, .clk_en,
		.osc_clk_tick, .stop_mode, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comparator_high,
		.channel_select, .converter_powered, .sample_hold, .dac_code,
		.conv_irq);
	adc_analog_model adc_analog_model_inst (.clk, .channel_select,
		.converter_powered, .dac_code, .vin_base, .comparator_high);
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_res(input logic [4:0] ch);
		if (ch == 5'h1D) return 8'hFF;
		if (ch == 5'h1E) return 8'h00;
		return vin_base + {ch, 3'h0};
	endfunction
	task automatic chk(input bit ok, input string m);
		checks_done++;
		if (!ok) begin
			errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bit pa = 1, pw = 1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (pa || pw) begin
			@(negedge clk);
			if (s_axi_awready) pa = 0;
			if (s_axi_wready) pw = 0;
			@(posedge clk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do @(negedge clk); while (!s_axi_bvalid);
		@(posedge clk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 0;
		do @(negedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata[7:0];
		@(posedge clk);
		s_axi_rready <= 0;
	endtask
	// Waits for the request line or the done bit, bounded
	task automatic wait_end(input bit irq, output int n);
		logic [7:0] s;
		n = 0;
		s = 0;
		while (n < 400 && !(irq ? conv_irq : s[7])) begin
			if (irq) @(negedge clk);
			else rd(4'h0, s);
			n++;
		end
	endtask
	task final_report;
		$display("errors=%0d checks=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report;
	end
	initial begin
		logic [7:0] d;
		logic [4:0] ch;
		int n, c, dv;
		void'($urandom(32'hEF81));
		repeat (6) @(posedge clk);
		rst_n <= 1;
		rd(4'h0, d);
		chk(d === 8'h1F && converter_powered === 0, "status reset");
		rd(4'h8, d);
		chk(d === 8'h00, "clock reset");
		// first conversions time each prescaler setting on the bus clock, the first one starting from power off
		for (c = 0; c < 6; c++) begin
			dv = c > 3 ? 16 : 1 << c;
			wr(4'h8, {c[2:0], 5'h10});
			wr(4'h0, 8'h40);
			wait_end(1, n);
			chk(n >= 16 * dv - 3 && n <= 17 * dv + 3, "conv time");
			rd(4'h4, d);
		end
		for (c = 0; c < 20; c++) begin
			ch = c < 15 ? c[4:0] : c == 15 ? 5'h1D : c == 16 ? 5'h1E
				: 5'($urandom % 15);
			vin_base <= 8'($urandom);
			wr(4'h0, {3'b010, ch});
			wait_end(1, n);
			rd(4'h4, d);
			chk(d === exp_res(ch) && s_axi_rresp === 2'h0, "result");
		end
		wr(4'h0, 8'hC3);
		rd(4'h0, d);
		chk(d[7] === 1'b1, "done writable");
		wait_end(1, n);
		rd(4'h4, d);
		wr(4'h0, 8'h23);
		wait_end(0, n);
		chk(conv_irq === 0 && n < 400, "done flag");
		rd(4'h4, d);
		wait_end(0, n);
		chk(n < 400, "repeat conversion");
		wr(4'h0, 8'h03);
		rd(4'h0, d);
		chk(d[7] === 1'b0, "write clears");
		wait_end(0, n);
		rd(4'h4, d);
		repeat (400) @(posedge clk);
		rd(4'h0, d);
		chk(d[7] === 1'b0, "single conversion");
		wr(4'h0, 8'h43);
		clk_en <= 0;
		repeat (3) @(posedge clk);
		clk_en <= 1;
		wait_end(1, n);
		chk(n >= 16 * 16 - 3 && n <= 17 * 16 + 3, "frozen conv");
		rd(4'h4, d);
		wr(4'h0, 8'h43);
		repeat (5) @(posedge clk);
		stop_mode <= 1;
		repeat (40) @(posedge clk);
		chk(conv_irq === 0, "stop aborts");
		stop_mode <= 0;
		repeat (300) @(posedge clk);
		chk(conv_irq === 0, "aborted conversion resumed");
		wr(4'h0, 8'h5F);
		repeat (40) @(posedge clk);
		chk(conv_irq === 0 && converter_powered === 0, "power off");
		rd(4'h2, d);
		chk(d === 8'h00 && s_axi_rresp === 2'h2, "unmapped read");
		final_report;
	end
endmodule // sar_adc_control_tb_top
`default_nettype wire
